// *** logic/timer_pkg.sv ***
package timer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_CLOCK     = 8'h04;
  localparam logic [7:0] OFF_IE        = 8'h08;
  localparam logic [7:0] OFF_COUNT_LO  = 8'h0C;
  localparam logic [7:0] OFF_COUNT_HI  = 8'h10;
  localparam logic [7:0] OFF_RELOAD_LO = 8'h14;
  localparam logic [7:0] OFF_RELOAD_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  localparam logic [7:0] OFF_CLEAR     = 8'h20;
  localparam logic [7:0] OFF_ENABLE    = 8'h24;

  // timer_control field positions
  localparam int CTL_HI_FLAG = 7;
  localparam int CTL_LO_FLAG = 6;
  localparam int CTL_LO_IRQ  = 5;
  localparam int CTL_CAPTURE = 4;
  localparam int CTL_SPLIT   = 3;
  localparam int CTL_RUN     = 2;
  localparam int CTL_RSVD    = 1;
  localparam int CTL_EXT     = 0;

  // clock_control and interrupt_enable field positions
  localparam int CLK_LO_SYS  = 0;
  localparam int CLK_HI_SYS  = 1;
  localparam int IE_TIMER    = 5;

  // Event bit positions in status, clear and enable registers
  localparam int EV_HI = 0;
  localparam int EV_LO = 1;

  // Values after reset
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_ENABLE = 2'h3;

  // Prescaler cycle counts
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  // Writable timer_control fields
  typedef struct packed {
    logic lo_irq_en;
    logic cap_en;
    logic split;
    logic run;
    logic ext_sel;
  } ctrl_s;

  // Sticky overflow flags
  typedef struct packed {
    logic lo;
    logic hi;
  } flags_s;

endpackage : timer_pkg

// *** logic/capture_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Sixteen-bit count held as two byte registers
// R2: Control bit 3 picks 16-bit or split mode
// R3: Count system_clock, system_clock/12 or synced external/8
// R4: 16-bit wrap outside capture mode reloads count, sets high flag
// R5: Timer enable interrupts on 16-bit wrap outside capture mode while high event enabled
// R6: Low flag enable adds low-byte wrap interrupts
// R7: Split bytes reload from their own reload bytes
// R8: Split: run gates high byte only
// R9: Per-byte select picks system_clock or slow source
// R10: Split: each byte wrap sets its flag
// R11: Split: high wrap interrupts, low wrap if enabled
// R12: Flags cleared only by software
// R13: Capture needs capture enable and split clear
// R14: Capture mode never counts external source
// R15: Comparator rise copies count, sets high flag
// R16: Software picks timer clock faster than comparator
// R17: Low flag set on low wrap in all modes
// R18: 16-bit counting steps per tick while running
// R19: Control bit 1 reads zero, ignores writes
module capture_timer
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,     // System clock
  input  wire logic              presetn,  // Async reset, active low
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB enable
  input  wire logic              pwrite,   // APB direction
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]       pwdata,   // APB write data
  output logic      [31:0]       prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // APB error, unmapped
  input  wire logic              ext_osc,  // External oscillator pin
  input  wire logic              cmp_out,  // Comparator output
  output logic                   irq       // Level interrupt
);

  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  ctrl_s       ctrl_reg;
  logic [1:0]  clk_sel_reg;
  logic        ie_reg;
  logic [7:0]  cnt_lo_reg;
  logic [7:0]  cnt_hi_reg;
  logic [7:0]  rld_lo_reg;
  logic [7:0]  rld_hi_reg;
  flags_s      flag_reg;
  logic [1:0]  mask_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        irq_reg;
  logic [3:0]  div12_reg;
  logic [2:0]  ext_cnt_reg;
  logic        ext_tick_reg;
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic        ext_s3_reg;
  logic        cmp_s1_reg;
  logic        cmp_s2_reg;
  logic        cmp_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pready_reg & pwrite;
  wire sel_ctl  = paddr == ADDR_W'(OFF_CONTROL);
  wire sel_clk  = paddr == ADDR_W'(OFF_CLOCK);
  wire sel_ie   = paddr == ADDR_W'(OFF_IE);
  wire sel_clo  = paddr == ADDR_W'(OFF_COUNT_LO);
  wire sel_chi  = paddr == ADDR_W'(OFF_COUNT_HI);
  wire sel_rlo  = paddr == ADDR_W'(OFF_RELOAD_LO);
  wire sel_rhi  = paddr == ADDR_W'(OFF_RELOAD_HI);
  wire sel_sts  = paddr == ADDR_W'(OFF_STATUS);
  wire sel_clr  = paddr == ADDR_W'(OFF_CLEAR);
  wire sel_ena  = paddr == ADDR_W'(OFF_ENABLE);
  wire hit      = sel_ctl | sel_clk | sel_ie | sel_clo | sel_chi |
                  sel_rlo | sel_rhi | sel_sts | sel_clr | sel_ena;
  wire wr_ctl   = wr_en & sel_ctl;
  wire wr_clk   = wr_en & sel_clk;
  wire wr_ie    = wr_en & sel_ie;
  wire wr_clo   = wr_en & sel_clo;
  wire wr_chi   = wr_en & sel_chi;
  wire wr_rlo   = wr_en & sel_rlo;
  wire wr_rhi   = wr_en & sel_rhi;
  wire wr_clr   = wr_en & sel_clr;
  wire wr_ena   = wr_en & sel_ena;

  // Control readback, reserved bit forced low
  wire [7:0] ctl_view = {flag_reg.hi, flag_reg.lo, ctrl_reg.lo_irq_en,
                         ctrl_reg.cap_en, ctrl_reg.split, ctrl_reg.run,
                         1'b0, ctrl_reg.ext_sel};                // R19

  // Read data selection
  wire [7:0] rd_byte =
      sel_ctl ? ctl_view :
      sel_clk ? {6'h00, clk_sel_reg} :
      sel_ie  ? {2'h0, ie_reg, 5'h00} :
      sel_clo ? cnt_lo_reg :                                     // R1
      sel_chi ? cnt_hi_reg :                                     // R1
      sel_rlo ? rld_lo_reg :
      sel_rhi ? rld_hi_reg :
      sel_sts ? {6'h00, flag_reg} :
      sel_ena ? {6'h00, mask_reg} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers and pin synchronisers
  wire div12_tick = div12_reg == SYS_DIV_LAST;                   // R3
  wire ext_rise   = ext_s2_reg & ~ext_s3_reg;
  wire cmp_rise   = cmp_s2_reg & ~cmp_s3_reg;

  // Divide-by-12, external rise counter, two-stage synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_reg    <= 4'h0;
      ext_cnt_reg  <= 3'h0;
      ext_tick_reg <= 1'b0;
      {ext_s1_reg, ext_s2_reg, ext_s3_reg} <= 3'h0;
      {cmp_s1_reg, cmp_s2_reg, cmp_s3_reg} <= 3'h0;
    end else begin
      div12_reg    <= div12_tick ? 4'h0 : div12_reg + 4'h1;      // R3
      ext_cnt_reg  <= ext_rise ? ext_cnt_reg + 3'h1 : ext_cnt_reg;
      ext_tick_reg <= ext_rise & (ext_cnt_reg == EXT_DIV_LAST);  // R3
      {ext_s1_reg, ext_s2_reg, ext_s3_reg} <=
          {ext_osc, ext_s1_reg, ext_s2_reg};
      {cmp_s1_reg, cmp_s2_reg, cmp_s3_reg} <=
          {cmp_out, cmp_s1_reg, cmp_s2_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and clock selection
  wire cap_mode = ctrl_reg.cap_en & ~ctrl_reg.split;             // R13
  wire slow_ext = ctrl_reg.ext_sel & ~cap_mode;                  // R14
  wire slow_tk  = slow_ext ? ext_tick_reg : div12_tick;          // R9
  wire lo_src   = clk_sel_reg[CLK_LO_SYS] | slow_tk;             // R9
  wire hi_src   = clk_sel_reg[CLK_HI_SYS] | slow_tk;             // R9
  wire lo_step  = ctrl_reg.split ? lo_src                        // R8
                                 : ctrl_reg.run & lo_src;        // R18
  wire lo_wrap  = lo_step & (cnt_lo_reg == 8'hFF);
  wire hi_inc   = ctrl_reg.split ? ctrl_reg.run & hi_src         // R8
                                 : lo_wrap;                      // R2
  wire hi_wrap  = hi_inc & (cnt_hi_reg == 8'hFF);
  wire lo_rld   = lo_wrap & (ctrl_reg.split |                    // R7
                             (hi_wrap & ~cap_mode));             // R4
  wire hi_rld   = hi_wrap & ~cap_mode;                           // R4
  wire cap_evt  = cap_mode & cmp_rise;                           // R15

  // Next count and reload values, software writes win over counting, capture wins over reload writes
  wire [7:0] cnt_lo_next =
      wr_clo  ? pwdata[7:0] :
      lo_rld  ? rld_lo_reg :
      lo_wrap ? 8'h00 :
      lo_step ? cnt_lo_reg + 8'h01 : cnt_lo_reg;
  wire [7:0] cnt_hi_next =
      wr_chi  ? pwdata[7:0] :
      hi_rld  ? rld_hi_reg :
      hi_wrap ? 8'h00 :
      hi_inc  ? cnt_hi_reg + 8'h01 : cnt_hi_reg;
  wire [7:0] rld_lo_next = cap_evt ? cnt_lo_reg :                // R15
                           wr_rlo  ? pwdata[7:0] : rld_lo_reg;
  wire [7:0] rld_hi_next = cap_evt ? cnt_hi_reg :                // R15
                           wr_rhi  ? pwdata[7:0] : rld_hi_reg;

  // Sticky flags, a new event wins over a clear
  wire    set_hi = hi_rld | cap_evt;                             // R10
  wire    set_lo = lo_wrap;                                      // R17
  flags_s flag_next;
  assign flag_next.hi = set_hi |                                 // R12
                        (flag_reg.hi & ~(wr_clr & pwdata[EV_HI]));
  assign flag_next.lo = set_lo |                                 // R12
                        (flag_reg.lo & ~(wr_clr & pwdata[EV_LO]));

  // Interrupt level from flags and enables
  wire irq_next = ie_reg &                                       // R5
                  ((flag_reg.hi & mask_reg[EV_HI]) |             // R11
                   (flag_reg.lo & ctrl_reg.lo_irq_en &           // R6
                    mask_reg[EV_LO]));

  ////////////////////////////////////////////////////////////////////////////
  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= '0;
      clk_sel_reg <= 2'h0;
      ie_reg      <= 1'b0;
      mask_reg    <= RST_ENABLE;
    end else begin
      if (wr_ctl) begin
        ctrl_reg <= {pwdata[CTL_LO_IRQ], pwdata[CTL_CAPTURE],
                     pwdata[CTL_SPLIT], pwdata[CTL_RUN],
                     pwdata[CTL_EXT]};                           // R2
      end
      if (wr_clk) begin
        clk_sel_reg <= pwdata[1:0];
      end
      if (wr_ie) begin
        ie_reg <= pwdata[IE_TIMER];
      end
      if (wr_ena) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // Counter, reload and flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_reg <= RST_BYTE;
      cnt_hi_reg <= RST_BYTE;
      rld_lo_reg <= RST_BYTE;
      rld_hi_reg <= RST_BYTE;
      flag_reg   <= '0;
      irq_reg    <= 1'b0;
    end else begin
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      rld_lo_reg <= rld_lo_next;
      rld_hi_reg <= rld_hi_next;
      flag_reg   <= flag_next;
      irq_reg    <= irq_next;
    end
  end

  // APB answer, registered in the setup cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~hit;
      if (setup) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rsvd_read_zero_a: assert property ( // R19
    setup & sel_ctl |=> !prdata[CTL_RSVD])
    else $error("reserved control bit read nonzero");

  flag_sticky_a: assert property ( // R12
    $fell(flag_reg.hi) |-> $past(wr_clr & pwdata[EV_HI]))
    else $error("high flag cleared without software");

  wrap16_reload_a: assert property ( // R4
    !ctrl_reg.split & !cap_mode & lo_step & !wr_clo & !wr_chi &
    cnt_lo_reg == 8'hFF & cnt_hi_reg == 8'hFF
    |=> cnt_lo_reg == $past(rld_lo_reg) &&
        cnt_hi_reg == $past(rld_hi_reg) && flag_reg.hi)
    else $error("16-bit wrap did not reload");

  irq_follow_a: assert property ( // R5
    ie_reg & flag_reg.hi & mask_reg[EV_HI] & !wr_ie & !wr_ena
    |=> irq)
    else $error("interrupt missing for high flag");

  low_free_run_a: assert property ( // R8
    ctrl_reg.split & !ctrl_reg.run & lo_src & !wr_clo &
    cnt_lo_reg != 8'hFF |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("split low byte stalled");

  high_gated_a: assert property ( // R8
    ctrl_reg.split & !ctrl_reg.run & !wr_chi |=> $stable(cnt_hi_reg))
    else $error("split high byte moved while stopped");

  capture_copy_a: assert property ( // R15
    cap_evt |=> rld_hi_reg == $past(cnt_hi_reg) &&
                rld_lo_reg == $past(cnt_lo_reg) && flag_reg.hi)
    else $error("capture did not copy count");

  div12_spacing_a: assert property ( // R3
    div12_tick |=> (!div12_tick)[*8] ##1 (!div12_tick)[*3] ##1 div12_tick)
    else $error("system clock divider period wrong");

  low_flag_16_a: assert property ( // R17
    lo_wrap & !ctrl_reg.split |=> flag_reg.lo)
    else $error("low flag missed in 16-bit mode");

  capture_no_ext_a: assert property ( // R14
    cap_mode & !clk_sel_reg[CLK_LO_SYS] |-> lo_src == div12_tick)
    else $error("capture mode took external source");

  // Independent tally of synchronised rises per external tick
  logic [3:0] rise_tally_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_tally_reg <= 4'h0;
    end else if (ext_tick_reg) begin
      rise_tally_reg <= ext_rise ? 4'h1 : 4'h0;
    end else if (ext_rise) begin
      rise_tally_reg <= rise_tally_reg + 4'h1;
    end
  end

  // External divider checks
  tick_tally_a: assert property ( // R3
    ext_tick_reg |-> rise_tally_reg == 4'(EXT_DIV))
    else $error("external tick not after eight rises");

  tick_missed_a: assert property ( // R3
    ext_rise |-> rise_tally_reg < 4'(EXT_DIV))
    else $error("external tick missing");

  tick_pulse_a: assert property ( // R3
    ext_tick_reg |=> !ext_tick_reg)
    else $error("external tick longer than one cycle");

  // Split mode, counting and flag checks
  low_sticky_a: assert property ( // R12
    $fell(flag_reg.lo) |-> $past(wr_clr & pwdata[EV_LO]))
    else $error("low flag cleared without software");

  split_low_reload_a: assert property ( // R7
    ctrl_reg.split & lo_wrap & !wr_clo |=> cnt_lo_reg == $past(rld_lo_reg))
    else $error("split low byte did not reload");

  split_high_reload_a: assert property ( // R7
    ctrl_reg.split & hi_wrap & !wr_chi |=> cnt_hi_reg == $past(rld_hi_reg))
    else $error("split high byte did not reload");

  split_high_flag_a: assert property ( // R10
    ctrl_reg.split & hi_wrap |=> flag_reg.hi)
    else $error("high flag missed in split mode");

  split_low_flag_a: assert property ( // R10
    ctrl_reg.split & lo_wrap |=> flag_reg.lo)
    else $error("low flag missed in split mode");

  sys_select_a: assert property ( // R9
    ctrl_reg.split & clk_sel_reg[CLK_LO_SYS] |-> lo_step)
    else $error("low byte not stepping on system clock");

  stopped_hold_a: assert property ( // R18
    !ctrl_reg.split & !ctrl_reg.run & !wr_clo |=> $stable(cnt_lo_reg))
    else $error("16-bit count moved while stopped");

  carry_step_a: assert property ( // R2
    !ctrl_reg.split & lo_wrap & !hi_wrap & !wr_chi
    |=> cnt_hi_reg == $past(cnt_hi_reg) + 8'h01)
    else $error("16-bit carry into high byte missed");

  split_no_capture_a: assert property ( // R13
    ctrl_reg.split & !wr_rlo |=> $stable(rld_lo_reg))
    else $error("reload changed by capture in split mode");

  // Interrupt checks
  low_irq_a: assert property ( // R6
    ie_reg & flag_reg.lo & ctrl_reg.lo_irq_en & mask_reg[EV_LO] |=> irq)
    else $error("interrupt missing for low flag");

  irq_off_a: assert property ( // R5
    !ie_reg |=> !irq)
    else $error("interrupt raised while timer interrupt off");

  capture_irq_a: assert property ( // R15
    cap_evt & ie_reg & mask_reg[EV_HI] & !wr_ie & !wr_ena |=> ##1 irq)
    else $error("capture did not interrupt");

endmodule : capture_timer

`default_nettype wire

// *** tb/osc_cmp_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module osc_cmp_model #(
  parameter int HALF_NS = 20,  // Oscillator half period, slower than pclk/4
  parameter int HIGH_NS = 200  // Comparator pulse width
) (
  input  wire logic kick,      // Request one comparator rise
  output logic      ext_osc,   // Free-running external oscillator
  output logic      cmp_out    // Comparator output
);
  ////////////////////////////////////////////////////////////////////////////
  // Free-running oscillator, phase unrelated to pclk
  initial begin
    ext_osc = 1'b0;
    #1.3;
    forever #(HALF_NS) ext_osc = ~ext_osc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wide pulse per request, far slower than the timer clock
  initial begin
    cmp_out = 1'b0;
    forever begin
      @(posedge kick);
      cmp_out = 1'b1;
      #(HIGH_NS) cmp_out = 1'b0;
    end
  end
endmodule : osc_cmp_model

`default_nettype wire

// *** tb/capture_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module capture_timer_tb;
  import timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, kick, serr;
  logic [7:0]  paddr, r;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, ext_osc, cmp_out, irq;
  int          err_total, n_compared;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and far side
  always #2 pclk = ~pclk;
  capture_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc(ext_osc), .cmp_out(cmp_out), .irq(irq));
  osc_cmp_model peer (.kick(kick), .ext_osc(ext_osc), .cmp_out(cmp_out));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task results;
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task rng(input string nm, input logic [7:0] v, input logic [7:0] lo,
           input logic [7:0] hi);
    chk(nm, {31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask : rng

  // One APB transfer, held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask : rdchk

  task irqchk(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irqchk

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; kick = 1'b0;
    err_total = 0; n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only bits, unmapped place
    rdchk("control", OFF_CONTROL, 32'h0);
    rdchk("enable", OFF_ENABLE, 32'h3);
    wr(OFF_CONTROL, 8'hF2);
    rdchk("control_ro", OFF_CONTROL, 32'h30);
    wr(OFF_CONTROL, 8'h00);
    rdchk("clear_reads", OFF_CLEAR, 32'h0);
    rdchk("unmapped", 8'h30, 32'h0);
    chk("unmapped_err", {31'h0, serr}, 32'h1);
    // Sixteen-bit wrap with reload
    wr(OFF_CLOCK, 8'h01); wr(OFF_RELOAD_LO, 8'h34); wr(OFF_RELOAD_HI, 8'h12);
    wr(OFF_COUNT_LO, 8'hF0); wr(OFF_COUNT_HI, 8'hFF); wr(OFF_IE, 8'h20);
    wr(OFF_CONTROL, 8'h04);
    repeat (24) @(posedge pclk);
    wr(OFF_CONTROL, 8'h00);
    rdchk("count_high", OFF_COUNT_HI, 32'h12);
    rdchk("status", OFF_STATUS, 32'h3);
    irqchk(1'b1);
    repeat (50) @(posedge pclk);
    rdchk("status_sticky", OFF_STATUS, 32'h3);
    wr(OFF_ENABLE, 8'h00);
    irqchk(1'b0);
    wr(OFF_ENABLE, 8'h03); wr(OFF_CLEAR, 8'h01);
    rdchk("status_clr", OFF_STATUS, 32'h2);
    irqchk(1'b0);
    wr(OFF_CONTROL, 8'h20);
    irqchk(1'b1);
    wr(OFF_CLEAR, 8'h02);
    irqchk(1'b0);
    // Split mode: low free-runs, high gated by run
    wr(OFF_CLOCK, 8'h03); wr(OFF_RELOAD_LO, 8'hA0); wr(OFF_COUNT_HI, 8'h05);
    wr(OFF_CONTROL, 8'h08); wr(OFF_COUNT_LO, 8'hF0);
    repeat (30) @(posedge pclk);
    rdchk("split_high", OFF_COUNT_HI, 32'h05);
    xfer(1'b0, OFF_COUNT_LO, 8'h00);
    rng("split_low", q[7:0], 8'hA0, 8'hD0);
    rdchk("split_status", OFF_STATUS, 32'h2);
    wr(OFF_RELOAD_HI, 8'h77); wr(OFF_COUNT_HI, 8'hFE); wr(OFF_CONTROL, 8'h0C);
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_STATUS, 8'h00);
    chk("split_hflag", {31'h0, q[0]}, 32'h1);
    irqchk(1'b1);
    xfer(1'b0, OFF_COUNT_HI, 8'h00);
    rng("split_hreload", q[7:0], 8'h77, 8'h90);
    wr(OFF_CONTROL, 8'h00); wr(OFF_CLEAR, 8'h03);
    // Divided system clock rate
    wr(OFF_CLOCK, 8'h00); wr(OFF_COUNT_LO, 8'h00); wr(OFF_CONTROL, 8'h04);
    repeat (240) @(posedge pclk);
    wr(OFF_CONTROL, 8'h00);
    xfer(1'b0, OFF_COUNT_LO, 8'h00);
    rng("div12", q[7:0], 8'h13, 8'h16);
    // External oscillator divided by 8
    wr(OFF_COUNT_LO, 8'h00); wr(OFF_CONTROL, 8'h05);
    repeat (800) @(posedge pclk);
    wr(OFF_CONTROL, 8'h01);
    xfer(1'b0, OFF_COUNT_LO, 8'h00);
    rng("ext_div8", q[7:0], 8'h09, 8'h0B);
    // No capture while split is set
    wr(OFF_CLEAR, 8'h03); wr(OFF_CONTROL, 8'h18);
    kick <= 1'b1; @(posedge pclk); kick <= 1'b0;
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_STATUS, 8'h00);
    chk("cap_split", {31'h0, q[0]}, 32'h0);
    // Capture counts system_clock/12 even with external select
    wr(OFF_COUNT_LO, 8'h00); wr(OFF_COUNT_HI, 8'h00); wr(OFF_CONTROL, 8'h15);
    repeat (240) @(posedge pclk);
    kick <= 1'b1; @(posedge pclk); kick <= 1'b0;
    repeat (10) @(posedge pclk);
    xfer(1'b0, OFF_RELOAD_LO, 8'h00);
    r = q[7:0];
    rng("cap_value", r, 8'h12, 8'h18);
    xfer(1'b0, OFF_COUNT_LO, 8'h00);
    rng("cap_copy", q[7:0] - r, 8'h00, 8'h02);
    rdchk("cap_status", OFF_STATUS, 32'h1);
    irqchk(1'b1);
    results();
  end
endmodule : capture_timer_tb

`default_nettype wire
